/* File: rtl/pphv_device.sv */
// Device end: command decode, page buffers, memories and erase/program engine
`timescale 1ns/1ps
module pphv_device #(
  parameter logic [7:0] SIG0 = 8'hA5, // arbitrary identity value
  parameter logic [7:0] SIG1 = 8'h5A, // arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h3C, // arbitrary identity value
  parameter logic [7:0] CALIB = 8'h80
) (
  input wire logic clock,
  input wire logic rst_b,
  pphv_if.dev link,
  output logic prog_mode,
  output logic [7:0] lock_bits
);
  import pphv_pkg::*;

  typedef enum {ST_IDLE, ST_ER_FLASH, ST_ER_EE, ST_ER_LOCK, ST_PG_FLASH, ST_PG_EE} pphv_st_type;
  localparam int PW = 17;

  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  logic [PW-1:0] pin_p_q;
  logic hv_s, oe_s, wr_s, bs1_s, bs2_s, ld_s, pl_s;
  logic [1:0] act_s;
  logic [7:0] bus_s;
  logic hv_rise, ld_rise, pl_rise, wr_fall;
  logic mode_q, entry_wait_q, pat_ok_q;
  logic [11:0] entry_cnt_q;
  logic [7:0] cmd_q, addr_lo_q, addr_hi_q, data_lo_q, data_hi_q;
  logic [7:0] fuse_lo_q, fuse_hi_q, fuse_ext_q, lock_q, rd_q, rd_d;
  pphv_st_type st_q;
  logic [FLASH_ADDR_W-1:0] idx_q;
  logic [15:0] flash_mem [0:(1<<FLASH_ADDR_W)-1];
  logic [7:0] ee_mem [0:(1<<EE_ADDR_W)-1];
  logic [15:0] flash_buf [0:(1<<FLASH_WORD_W)-1];
  logic [7:0] ee_buf [0:(1<<EE_BYTE_W)-1];
  logic [FLASH_ADDR_W-1:0] flash_addr;
  logic [EE_ADDR_W-1:0] ee_addr;
  logic go;

  function automatic logic known_cmd(input logic [7:0] c);
    case (c)
      CMD_ERASE, CMD_WR_FUSE, CMD_WR_LOCK, CMD_WR_FLASH, CMD_WR_EE,
      CMD_RD_SIG, CMD_RD_FUSE, CMD_RD_FLASH, CMD_RD_EE: known_cmd = 1'b1;
      default: known_cmd = 1'b0;
    endcase
  endfunction

  assign pin_raw = {link.hv_reset, link.output_enable_n, link.write_strobe_n,
                    link.byte_sel_lo_hi, link.byte_sel_ext, link.action_sel_bit1,
                    link.action_sel_bit0, link.load_strobe, link.page_latch_strobe,
                    link.data_bus};
  assign {hv_s, oe_s, wr_s, bs1_s, bs2_s, act_s, ld_s, pl_s, bus_s} = pin_s2_q;
  assign hv_rise = hv_s && !pin_p_q[16];
  assign wr_fall = !wr_s && pin_p_q[14];
  assign ld_rise = ld_s && !pin_p_q[9];
  assign pl_rise = pl_s && !pin_p_q[8];
  assign go = mode_q && !entry_wait_q;
  assign flash_addr = FLASH_ADDR_W'({addr_hi_q, addr_lo_q});
  assign ee_addr = EE_ADDR_W'({addr_hi_q, addr_lo_q});

  // Pins come from another party, so two flops before use
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_p_q <= '0;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_p_q <= pin_s2_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b || !hv_s)
    begin
      mode_q <= 1'b0;
      entry_wait_q <= 1'b0;
      pat_ok_q <= 1'b0;
      entry_cnt_q <= '0;
    end
    else if (hv_rise)
    begin
      entry_wait_q <= 1'b1;
      entry_cnt_q <= '0;
      pat_ok_q <= ({pl_s, act_s, bs1_s} == ENTRY_PATTERN);
    end
    else if (entry_wait_q)
    begin
      entry_cnt_q <= entry_cnt_q + 12'h001;
      if (entry_cnt_q == 12'(ENTRY_HOLD_CYC - 1))
      begin
        entry_wait_q <= 1'b0;
        mode_q <= pat_ok_q && ({pl_s, act_s, bs1_s} == ENTRY_PATTERN);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b || !mode_q)
    begin
      cmd_q <= CMD_NOP;
      addr_lo_q <= '0;
      addr_hi_q <= '0;
      data_lo_q <= '0;
      data_hi_q <= '0;
    end
    else if (go && ld_rise)
    begin
      case (act_s)
        ACT_ADDR:
        begin
          if (bs1_s)
            addr_hi_q <= bus_s;
          else
            addr_lo_q <= bus_s;
        end
        ACT_DATA:
        begin
          if (bs1_s)
            data_hi_q <= bus_s;
          else
            data_lo_q <= bus_s;
        end
        ACT_CMD:
        begin
          if (bus_s == CMD_NOP)
            cmd_q <= CMD_NOP;
          else if (known_cmd(bus_s))
            cmd_q <= bus_s;
        end
        default:
          cmd_q <= cmd_q;
      endcase
    end
  end

  // Page latch into buffer
  // Buffer words go back to erased once used, so unlatched words program as blank
  always_ff @(posedge clock)
  begin
    if (st_q == ST_ER_FLASH)
    begin
      flash_buf[idx_q[FLASH_WORD_W-1:0]] <= {ERASED_BYTE, ERASED_BYTE};
      ee_buf[idx_q[EE_BYTE_W-1:0]] <= ERASED_BYTE;
    end
    else if (st_q == ST_PG_FLASH)
      flash_buf[idx_q[FLASH_WORD_W-1:0]] <= {ERASED_BYTE, ERASED_BYTE};
    else if (st_q == ST_PG_EE)
      ee_buf[idx_q[EE_BYTE_W-1:0]] <= ERASED_BYTE;
    else if (go && pl_rise)
    begin
      if (cmd_q == CMD_WR_EE)
        ee_buf[addr_lo_q[EE_BYTE_W-1:0]] <= data_lo_q;
      else if (cmd_q == CMD_WR_FLASH)
        flash_buf[addr_lo_q[FLASH_WORD_W-1:0]] <= {data_hi_q, data_lo_q};
    end
  end

  // Command and address kept
  // Erase and page program engine; command and address stay loaded
  always_ff @(posedge clock)
  begin
    if (!rst_b || !mode_q)
    begin
      st_q <= ST_IDLE;
      idx_q <= '0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          idx_q <= '0;
          if (go && wr_fall)
          begin
            case (cmd_q)
              CMD_ERASE: st_q <= ST_ER_FLASH;
              CMD_WR_FLASH: st_q <= ST_PG_FLASH;
              CMD_WR_EE: st_q <= ST_PG_EE;
              default: st_q <= ST_IDLE;
            endcase
          end
        end
        ST_ER_FLASH:
        begin
          idx_q <= idx_q + 1'b1;
          if (&idx_q)
          begin
            idx_q <= '0;
            st_q <= fuse_hi_q[KEEP_EE_BIT] ? ST_ER_EE : ST_ER_LOCK;
          end
        end
        ST_ER_EE:
        begin
          idx_q <= idx_q + 1'b1;
          if (&idx_q[EE_ADDR_W-1:0])
            st_q <= ST_ER_LOCK;
        end
        ST_ER_LOCK:
          st_q <= ST_IDLE;
        ST_PG_FLASH:
        begin
          idx_q <= idx_q + 1'b1;
          if (&idx_q[FLASH_WORD_W-1:0])
            st_q <= ST_IDLE;
        end
        ST_PG_EE:
        begin
          idx_q <= idx_q + 1'b1;
          if (&idx_q[EE_BYTE_W-1:0])
            st_q <= ST_IDLE;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Memory writes; arrays carry no reset so erase is the only clear
  always_ff @(posedge clock)
  begin
    case (st_q)
      ST_ER_FLASH:
        flash_mem[idx_q] <= {ERASED_BYTE, ERASED_BYTE};
      ST_ER_EE:
        ee_mem[idx_q[EE_ADDR_W-1:0]] <= ERASED_BYTE;
      ST_PG_FLASH:
        flash_mem[{flash_addr[FLASH_ADDR_W-1:FLASH_WORD_W], idx_q[FLASH_WORD_W-1:0]}]
          <= flash_buf[idx_q[FLASH_WORD_W-1:0]];
      ST_PG_EE:
        ee_mem[{ee_addr[EE_ADDR_W-1:EE_BYTE_W], idx_q[EE_BYTE_W-1:0]}]
          <= ee_buf[idx_q[EE_BYTE_W-1:0]];
      default:
        ;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      fuse_lo_q <= FUSE_LO_RST;
      fuse_hi_q <= FUSE_HI_RST;
      fuse_ext_q <= FUSE_EXT_RST;
      lock_q <= LOCK_RST;
    end
    else if (st_q == ST_ER_LOCK)
      lock_q <= LOCK_RST;
    else if (go && wr_fall && st_q == ST_IDLE)
    begin
      if (cmd_q == CMD_WR_LOCK)
        lock_q <= lock_q & data_lo_q;
      else if (cmd_q == CMD_WR_FUSE)
      begin
        if (bs2_s)
          fuse_ext_q <= data_lo_q;
        else if (bs1_s)
          fuse_hi_q <= data_lo_q;
        else
          fuse_lo_q <= data_lo_q;
      end
    end
  end

  always_comb
  begin
    rd_d = BUS_IDLE;
    case (cmd_q)
      CMD_RD_FLASH:
        rd_d = bs1_s ? flash_mem[flash_addr][15:8] : flash_mem[flash_addr][7:0];
      CMD_RD_EE:
        rd_d = ee_mem[ee_addr];
      CMD_RD_SIG:
        if (bs1_s)
          rd_d = CALIB;
        else if (addr_lo_q[1:0] == 2'h0)
          rd_d = SIG0;
        else if (addr_lo_q[1:0] == 2'h1)
          rd_d = SIG1;
        else
          rd_d = SIG2;
      CMD_RD_FUSE:
        case ({bs2_s, bs1_s})
          2'h0: rd_d = fuse_lo_q;
          2'h1: rd_d = lock_q;
          2'h2: rd_d = fuse_ext_q;
          default: rd_d = fuse_hi_q;
        endcase
      default:
        rd_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rd_q <= BUS_IDLE;
    else
      rd_q <= rd_d;
  end

  // Drive bus only on output enable
  assign link.data_dev_oe_n = !(go && !oe_s);
  assign link.data_dev = rd_q;
  assign link.ready_busy_n = (st_q == ST_IDLE);
  assign prog_mode = mode_q;
  assign lock_bits = lock_q;
endmodule // pphv_device

/* File: rtl/pphv_if.sv */
// Pin bundle between the programmer and the device
`timescale 1ns/1ps
interface pphv_if;
  logic hv_reset;
  logic ready_busy_n;
  logic output_enable_n;
  logic write_strobe_n;
  logic byte_sel_lo_hi;
  logic byte_sel_ext;
  logic action_sel_bit0;
  logic action_sel_bit1;
  logic load_strobe;
  logic page_latch_strobe;
  logic [7:0] data_dev;
  logic data_dev_oe_n;
  logic [7:0] data_prog;
  logic data_prog_oe_n;
  logic [7:0] data_bus;
  // Undriven bus floats high
  assign data_bus = !data_dev_oe_n ? data_dev
                  : (!data_prog_oe_n ? data_prog : pphv_pkg::BUS_IDLE);
  modport dev (
    input hv_reset, output_enable_n, write_strobe_n, byte_sel_lo_hi, byte_sel_ext,
    input action_sel_bit0, action_sel_bit1, load_strobe, page_latch_strobe, data_bus,
    output ready_busy_n, data_dev, data_dev_oe_n
  );
  modport prog (
    output hv_reset, output_enable_n, write_strobe_n, byte_sel_lo_hi, byte_sel_ext,
    output action_sel_bit0, action_sel_bit1, load_strobe, page_latch_strobe,
    output data_prog, data_prog_oe_n,
    input ready_busy_n, data_bus
  );
endinterface

/* File: rtl/pphv_pkg.sv */
// Shared constants and types for the parallel high-voltage program port
// Functional notes
// - ready_busy_n low while busy, high when ready
// - Device drives data only while output_enable_n low
// - Address load: byte_sel_lo_hi picks low/high byte
// - byte_sel_ext picks low or extended byte
// - Enter mode only with entry pattern 0000
// - Load strobe action: address, data, command, idle
// - Decode write commands: erase, fuse, lock, flash, eeprom
// - Decode read commands: signature, fuse/lock, flash, eeprom
// - Flash: 256 pages of 64 words
// - EEPROM: 256 pages of 4 bytes
// - Entry pattern held 10 us after high voltage
// - Programmer waits 300 us before commands
// - Leave mode when high voltage removed
// - Command and address kept across operations
// - Erase flash, eeprom, then lock bits; fuses kept
// - Keep-eeprom fuse protects eeprom from erase
// - Write strobe after erase command starts erase
// - Data load: byte_sel_lo_hi picks low/high data
// - Page latch copies data word into buffer
// - Upper low-address bits select page on write
// - Write strobe programs whole page, busy until done
// - Reload high address only on new window
// - No-operation command clears write state
package pphv_pkg;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [3:0] ENTRY_PATTERN = 4'h0;
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] FUSE_LO_RST = 8'h62;
  localparam logic [7:0] FUSE_HI_RST = 8'h99;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam int KEEP_EE_BIT = 3;
  localparam int FLASH_WORD_W = 6;
  localparam int FLASH_PAGE_W = 8;
  localparam int FLASH_ADDR_W = FLASH_WORD_W + FLASH_PAGE_W;
  localparam int EE_BYTE_W = 2;
  localparam int EE_PAGE_W = 8;
  localparam int EE_ADDR_W = EE_BYTE_W + EE_PAGE_W;
  localparam int CLK_MHZ = 250;
  localparam int ENTRY_HOLD_US = 10;
  localparam int ENTRY_HOLD_CYC = ENTRY_HOLD_US * CLK_MHZ;
  localparam int CMD_WAIT_US = 300;
  localparam int CMD_WAIT_CYC = CMD_WAIT_US * CLK_MHZ;
  localparam int PULSE_NS = 250;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_NS = 67;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    OP_ENTER, OP_CMD, OP_ADDR, OP_DATA, OP_LATCH, OP_WRITE, OP_READ, OP_EXIT
  } pphv_op_type;
endpackage

/* File: rtl/pphv_programmer.sv */
// Programmer end: turns user operations into timed strobe sequences
`timescale 1ns/1ps
module pphv_programmer #(
  parameter int CMD_WAIT_CYCLES = pphv_pkg::CMD_WAIT_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  pphv_if.prog link,
  input wire logic op_valid,
  input wire pphv_pkg::pphv_op_type op,
  input wire logic [7:0] op_byte,
  input wire logic op_bs1,
  input wire logic op_bs2,
  output logic op_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic in_mode
);
  import pphv_pkg::*;

  typedef enum {P_OFF, P_HV, P_IDLE, P_SETUP, P_PULSE, P_HOLD, P_WAIT, P_READ} pphv_pst_type;

  pphv_pst_type st_q;
  pphv_op_type op_q;
  logic [31:0] cnt_q;
  logic rdy_s1_q, rdy_s2_q;
  logic [7:0] bus_s1_q, bus_s2_q, hi_q;
  logic hi_ok_q;
  logic [1:0] act_q;
  logic bs1_q, bs2_q, ld_q, pl_q, wr_n_q, oe_n_q, hv_q, dout_oe_n_q;
  logic [7:0] dout_q;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      bus_s1_q <= BUS_IDLE;
      bus_s2_q <= BUS_IDLE;
    end
    else
    begin
      rdy_s1_q <= link.ready_busy_n;
      rdy_s2_q <= rdy_s1_q;
      bus_s1_q <= link.data_bus;
      bus_s2_q <= bus_s1_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      st_q <= P_OFF;
      op_q <= OP_CMD;
      cnt_q <= '0;
      hi_q <= '0;
      hi_ok_q <= 1'b0;
      act_q <= '0;
      {bs1_q, bs2_q, ld_q, pl_q, hv_q} <= '0;
      {wr_n_q, oe_n_q, dout_oe_n_q} <= 3'h7;
      dout_q <= '0;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      cnt_q <= cnt_q + 32'h1;
      case (st_q)
        P_OFF:
          if (op_valid && op == OP_ENTER)
          begin
            {pl_q, act_q, bs1_q, bs2_q} <= '0;
            hv_q <= 1'b1;
            hi_ok_q <= 1'b0;
            cnt_q <= '0;
            st_q <= P_HV;
          end
        P_HV:
          if (cnt_q >= 32'(CMD_WAIT_CYCLES - 1))
            st_q <= P_IDLE;
        P_IDLE:
          if (op_valid)
          begin
            op_q <= op;
            cnt_q <= '0;
            bs1_q <= op_bs1;
            bs2_q <= op_bs2;
            dout_q <= op_byte;
            if (op == OP_EXIT)
            begin
              hv_q <= 1'b0;
              st_q <= P_OFF;
            end
            // High address only on new window
            else if (op == OP_ADDR && op_bs1 && hi_ok_q && op_byte == hi_q)
              st_q <= P_IDLE;
            else if (op == OP_READ)
            begin
              dout_oe_n_q <= 1'b1;
              oe_n_q <= 1'b0;
              st_q <= P_READ;
            end
            else if (op != OP_ENTER)
            begin
              dout_oe_n_q <= 1'b0;
              act_q <= (op == OP_CMD) ? ACT_CMD : ((op == OP_DATA) ? ACT_DATA : ACT_ADDR);
              if (op == OP_ADDR && op_bs1)
              begin
                hi_q <= op_byte;
                hi_ok_q <= 1'b1;
              end
              st_q <= P_SETUP;
            end
          end
        P_SETUP:
          if (cnt_q >= 32'(SETUP_CYC - 1))
          begin
            cnt_q <= '0;
            ld_q <= (op_q == OP_CMD || op_q == OP_ADDR || op_q == OP_DATA);
            pl_q <= (op_q == OP_LATCH);
            wr_n_q <= (op_q != OP_WRITE);
            st_q <= P_PULSE;
          end
        P_PULSE:
          if (cnt_q >= 32'(PULSE_CYC - 1))
          begin
            cnt_q <= '0;
            {ld_q, pl_q} <= 2'h0;
            wr_n_q <= 1'b1;
            st_q <= P_HOLD;
          end
        P_HOLD:
          if (cnt_q >= 32'(SETUP_CYC - 1))
            st_q <= (op_q == OP_WRITE) ? P_WAIT : P_IDLE;
        P_WAIT:
          if (rdy_s2_q)
            st_q <= P_IDLE;
        // Bus sampled late enough to cover both sync stages
        P_READ:
          if (cnt_q >= 32'(PULSE_CYC - 1))
          begin
            oe_n_q <= 1'b1;
            rd_data <= bus_s2_q;
            rd_valid <= 1'b1;
            st_q <= P_IDLE;
          end
        default:
          st_q <= P_OFF;
      endcase
    end
  end

  assign op_ready = (st_q == P_OFF) || (st_q == P_IDLE);
  assign in_mode = (st_q != P_OFF) && (st_q != P_HV);
  assign link.hv_reset = hv_q;
  assign link.output_enable_n = oe_n_q;
  assign link.write_strobe_n = wr_n_q;
  assign link.byte_sel_lo_hi = bs1_q;
  assign link.byte_sel_ext = bs2_q;
  assign link.action_sel_bit0 = act_q[0];
  assign link.action_sel_bit1 = act_q[1];
  assign link.load_strobe = ld_q;
  assign link.page_latch_strobe = pl_q;
  assign link.data_prog = dout_q;
  assign link.data_prog_oe_n = dout_oe_n_q;
endmodule // pphv_programmer

/* File: testbench/parallel_hv_program_port_tb.sv */
// Self-checking bench joining the programmer end to the device end
`timescale 1ns/1ps
module parallel_hv_program_port_tb;
  import pphv_pkg::*;
  localparam int CMD_WAIT = 3000;
  localparam logic [7:0] SIG_A = 8'hA5; // arbitrary identity value
  localparam logic [7:0] SIG_B = 8'h5A; // arbitrary identity value
  localparam logic [7:0] SIG_C = 8'h3C; // arbitrary identity value
  localparam logic [7:0] CAL_V = 8'h80;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic op_valid = 1'b0;
  pphv_op_type op = OP_ENTER;
  logic [7:0] op_byte = 8'h00;
  logic op_bs1 = 1'b0;
  logic op_bs2 = 1'b0;
  logic op_ready;
  logic rd_valid;
  logic in_mode;
  logic prog_mode;
  logic [7:0] rd_data;
  logic [7:0] lock_bits;
  logic [7:0] exp_q[$];
  logic [7:0] addr_lo;
  logic [7:0] addr_hi;
  logic [7:0] data_lo;
  logic [7:0] data_hi;
  int errors = 0;
  int comparisons = 0;
  int seed = 32'h8B9C;
  always #2 clock = ~clock;
  pphv_if u_pphv_if ();
  pphv_device #(.SIG0(SIG_A), .SIG1(SIG_B), .SIG2(SIG_C), .CALIB(CAL_V)) u_pphv_device (
    .clock(clock), .rst_b(rst_b), .link(u_pphv_if), .prog_mode(prog_mode), .lock_bits(lock_bits)
  );
  pphv_programmer #(.CMD_WAIT_CYCLES(CMD_WAIT)) u_pphv_programmer (
    .clock(clock), .rst_b(rst_b), .link(u_pphv_if), .op_valid(op_valid), .op(op),
    .op_byte(op_byte), .op_bs1(op_bs1), .op_bs2(op_bs2), .op_ready(op_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .in_mode(in_mode)
  );
  pphv_assertions #(.CMD_WAIT_CYCLES(CMD_WAIT)) u_pphv_assertions (
    .clock(clock), .rst_b(rst_b), .hv_reset(u_pphv_if.hv_reset),
    .ready_busy_n(u_pphv_if.ready_busy_n), .output_enable_n(u_pphv_if.output_enable_n),
    .write_strobe_n(u_pphv_if.write_strobe_n), .byte_sel_lo_hi(u_pphv_if.byte_sel_lo_hi),
    .action_sel_bit0(u_pphv_if.action_sel_bit0), .action_sel_bit1(u_pphv_if.action_sel_bit1),
    .load_strobe(u_pphv_if.load_strobe), .page_latch_strobe(u_pphv_if.page_latch_strobe),
    .data_bus(u_pphv_if.data_bus), .data_dev_oe_n(u_pphv_if.data_dev_oe_n)
  );
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hold the request until taken, then wait for the sequence to finish
  task automatic do_op(input pphv_op_type o, input logic [7:0] b, input logic s1, input logic s2);
    int n;
    @(negedge clock);
    op_valid = 1'b1;
    op = o;
    op_byte = b;
    op_bs1 = s1;
    op_bs2 = s2;
    n = 0;
    while (op_ready !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    op_valid = 1'b0;
    n = 0;
    while (op_ready !== 1'b1 && n < 40000)
    begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic do_read(input logic s1, input logic s2, input logic [7:0] exp);
    exp_q.push_back(exp);
    do_op(OP_READ, 8'h00, s1, s2);
  endtask
  // Empty queue yields an unknown note, so a stray read mismatches unless the byte read is itself all unknown
  always @(negedge clock)
    if (rd_valid === 1'b1)
    begin
      check8(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end
  initial
  begin
    repeat (80000) @(posedge clock);
    errors++;
    give_verdict;
  end
  initial
  begin
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    do_op(OP_ENTER, 8'h00, 1'b0, 1'b0);
    check1(prog_mode, 1'b1);
    do_op(OP_CMD, CMD_WR_LOCK, 1'b0, 1'b0);
    do_op(OP_DATA, 8'hC0, 1'b0, 1'b0);
    do_op(OP_WRITE, 8'h00, 1'b0, 1'b0);
    check8(lock_bits, 8'hC0);
    do_op(OP_CMD, CMD_RD_FUSE, 1'b0, 1'b0);
    do_read(1'b1, 1'b0, 8'hC0);
    do_read(1'b1, 1'b1, FUSE_HI_RST);
    do_read(1'b0, 1'b1, FUSE_EXT_RST);
    do_op(OP_CMD, CMD_ERASE, 1'b0, 1'b0);
    do_op(OP_WRITE, 8'h00, 1'b0, 1'b0);
    check8(lock_bits, LOCK_RST);
    do_op(OP_CMD, CMD_RD_FUSE, 1'b0, 1'b0);
    do_read(1'b0, 1'b0, FUSE_LO_RST);
    addr_lo = 8'($random(seed));
    addr_hi = 8'($random(seed)) & 8'h3F;
    data_lo = 8'($random(seed));
    data_hi = 8'($random(seed));
    do_op(OP_CMD, CMD_WR_FLASH, 1'b0, 1'b0);
    do_op(OP_ADDR, addr_lo, 1'b0, 1'b0);
    do_op(OP_DATA, data_lo, 1'b0, 1'b0);
    do_op(OP_DATA, data_hi, 1'b1, 1'b0);
    do_op(OP_LATCH, 8'h00, 1'b1, 1'b0);
    do_op(OP_ADDR, addr_hi, 1'b1, 1'b0);
    do_op(OP_WRITE, 8'h00, 1'b0, 1'b0);
    // Address is not reloaded: the device must have kept it
    do_op(OP_CMD, CMD_RD_FLASH, 1'b0, 1'b0);
    do_read(1'b0, 1'b0, data_lo);
    do_read(1'b1, 1'b0, data_hi);
    do_op(OP_ADDR, addr_lo ^ 8'h01, 1'b0, 1'b0);
    do_read(1'b0, 1'b0, ERASED_BYTE);
    do_op(OP_CMD, CMD_RD_SIG, 1'b0, 1'b0);
    do_op(OP_ADDR, 8'h00, 1'b0, 1'b0);
    do_read(1'b0, 1'b0, SIG_A);
    do_read(1'b1, 1'b0, CAL_V);
    do_op(OP_ADDR, 8'h01, 1'b0, 1'b0);
    do_read(1'b0, 1'b0, SIG_B);
    do_op(OP_ADDR, 8'h02, 1'b0, 1'b0);
    do_read(1'b0, 1'b0, SIG_C);
    do_op(OP_EXIT, 8'h00, 1'b0, 1'b0);
    repeat (6) @(negedge clock);
    check1(prog_mode, 1'b0);
    give_verdict;
  end
endmodule // parallel_hv_program_port_tb

/* File: testbench/pphv_assertions.sv */
// Concurrent checks on the pins between programmer and device
`timescale 1ns/1ps
module pphv_assertions #(
  parameter int CMD_WAIT_CYCLES = 3000
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hv_reset,
  input wire logic ready_busy_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic byte_sel_lo_hi,
  input wire logic action_sel_bit0,
  input wire logic action_sel_bit1,
  input wire logic load_strobe,
  input wire logic page_latch_strobe,
  input wire logic [7:0] data_bus,
  input wire logic data_dev_oe_n
);
  import pphv_pkg::*;
  // Keep fuse left unprogrammed in the bench, so eeprom erase time is included
  localparam int ERASE_CYC = 16384 + 1024 + 1;
  localparam int PAGE_CYC = 64;
  logic [7:0] cmd_q;
  int busy_q;
  int hv_cnt_q;
  logic entry_zero;
  logic long_op;
  assign entry_zero = !page_latch_strobe && !action_sel_bit1 && !action_sel_bit0 && !byte_sel_lo_hi;
  assign long_op = cmd_q == CMD_ERASE || cmd_q == CMD_WR_FLASH || cmd_q == CMD_WR_EE;
  // Shadow of the last command byte seen on the wire
  always_ff @(posedge clock)
    if (!rst_b)
      cmd_q <= CMD_NOP;
    else if ($rose(load_strobe) && {action_sel_bit1, action_sel_bit0} == ACT_CMD)
      cmd_q <= data_bus;
  always_ff @(posedge clock)
    if (!rst_b || ready_busy_n)
      busy_q <= 0;
    else
      busy_q <= busy_q + 1;
  // Saturates so a long session cannot wrap it
  always_ff @(posedge clock)
    if (!rst_b || !hv_reset)
      hv_cnt_q <= 0;
    else if (hv_cnt_q < CMD_WAIT_CYCLES)
      hv_cnt_q <= hv_cnt_q + 1;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence long_start;
    $fell(write_strobe_n) && ready_busy_n && long_op;
  endsequence
  sequence busy_run;
    !ready_busy_n [*3];
  endsequence
  a_busy_on_write: assert property (long_start |-> ##4 busy_run)
    else $error("busy did not follow write strobe");
  a_busy_cause: assert property ($fell(ready_busy_n) |-> !$past(write_strobe_n, 3))
    else $error("busy without write strobe");
  a_busy_only_long: assert property (!ready_busy_n |-> long_op)
    else $error("busy for a command without busy phase");
  a_erase_time: assert property ($rose(ready_busy_n) && cmd_q == CMD_ERASE |-> busy_q == ERASE_CYC)
    else $error("erase busy length wrong");
  a_page_time: assert property ($rose(ready_busy_n) && cmd_q == CMD_WR_FLASH |-> busy_q == PAGE_CYC)
    else $error("page write busy length wrong");
  a_drive_needs_oe: assert property (!data_dev_oe_n |-> !$past(output_enable_n, 2))
    else $error("device drives bus without output enable");
  a_release_bus: assert property (output_enable_n [*4] |-> data_dev_oe_n)
    else $error("device still drives after output enable rose");
  a_idle_off_mode: assert property (!hv_reset [*4] |-> data_dev_oe_n && ready_busy_n)
    else $error("device active outside programming mode");
  a_entry_pattern: assert property ($rose(hv_reset) |-> entry_zero)
    else $error("entry pattern not zero at high voltage");
  a_entry_hold: assert property (hv_reset && hv_cnt_q < ENTRY_HOLD_CYC |-> entry_zero)
    else $error("entry pattern changed too early");
  a_cmd_wait: assert property ($rose(load_strobe) |-> hv_cnt_q == CMD_WAIT_CYCLES)
    else $error("load before entry wait elapsed");
endmodule // pphv_assertions
